// ==== logic/eqb_pkg.sv ====
// Package of the indexed control bank: host register offsets, index map,
// field positions and reset values.
// Assumes a 16-bit host register port clocked by clk_sys.
package eqb_pkg;

    // ************************************************************
    // Host-visible registers
    // ************************************************************
    localparam logic [7:0]  HOST_INDEX_ADDR = 8'h6a;
    localparam logic [7:0]  HOST_INDEX_DATA = 8'h6c;
    localparam logic [7:0]  HOST_EQ_STATUS  = 8'h6e;
    localparam int          INDEX_W         = 7;

    // ************************************************************
    // Index map
    // ************************************************************
    localparam logic [6:0]  IDX_EQ_CTRL     = 7'h10;
    localparam logic [6:0]  IDX_EQ_IN       = 7'h11;
    localparam logic [6:0]  IDX_EQ_OUT      = 7'h12;
    localparam logic [6:0]  IDX_AV_CFG      = 7'h20;
    localparam logic [6:0]  IDX_AV_MAX      = 7'h21;
    localparam logic [6:0]  IDX_AV_MIN      = 7'h22;
    localparam logic [6:0]  IDX_AV_IDLE     = 7'h23;
    localparam logic [6:0]  IDX_AV_RAISE    = 7'h24;
    localparam logic [6:0]  IDX_AV_LOWER    = 7'h25;
    localparam logic [6:0]  IDX_DIG_MISC    = 7'h39;
    localparam logic [6:0]  IDX_SPK_POWER   = 7'h44;
    localparam logic [6:0]  IDX_SPK_TEMP    = 7'h4a;
    localparam logic [6:0]  IDX_MIX_REF     = 7'h54;
    localparam logic [6:0]  IDX_FALLBACK    = 7'h00;

    // ************************************************************
    // Writable-bit masks and reset values
    // ************************************************************
    localparam logic [15:0] MASK_EQ_CTRL    = 16'h801f;
    localparam logic [15:0] MASK_EQ_IN      = 16'h0003;
    localparam logic [15:0] MASK_EQ_OUT     = 16'h0007;
    localparam logic [15:0] MASK_AV_CFG     = 16'h80f9;
    localparam logic [15:0] MASK_LEVEL15    = 16'h7fff;
    localparam logic [15:0] MASK_FULL       = 16'hffff;
    localparam logic [15:0] MASK_SPK_TEMP   = 16'h7777;
    localparam logic [15:0] RST_EQ_CTRL     = 16'h0000;
    localparam logic [15:0] RST_EQ_IN       = 16'h0000;
    localparam logic [15:0] RST_EQ_OUT      = 16'h0001;
    localparam logic [15:0] RST_AV_CFG      = 16'h0050;
    localparam logic [15:0] RST_AV_MAX      = 16'h2710;
    localparam logic [15:0] RST_AV_MIN      = 16'h0bb8;
    localparam logic [15:0] RST_AV_IDLE     = 16'h01f4;
    localparam logic [15:0] RST_AV_RAISE    = 16'h0190;
    localparam logic [15:0] RST_AV_LOWER    = 16'h0200;
    localparam logic [15:0] RST_DIG_MISC    = 16'h9000;
    localparam logic [15:0] RST_SPK_POWER   = 16'hf920;
    localparam logic [15:0] RST_SPK_TEMP    = 16'h4444;
    localparam logic [15:0] RST_MIX_REF     = 16'h8184;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          EQ_EN_BIT       = 15;
    localparam int          AV_EN_BIT       = 15;
    localparam int          AV_WIN_LSB      = 3;
    localparam logic [4:0]  AV_WIN_MAX      = 5'h10;
    localparam int          PAD_STRONG_BIT  = 15;
    localparam int          VDAC_HPF_BIT    = 12;
    localparam int          SPK_PWR_LSB     = 12;
    localparam int          MIX_REF_LSB     = 13;
    localparam logic [1:0]  MIX_REF_INT     = 2'h1;
    localparam logic [1:0]  MIX_REF_EXT     = 2'h3;
    localparam int          NUM_BANDS       = 5;
    localparam int          NUM_REGS        = 13;

endpackage : eqb_pkg

// ==== logic/eqb_status_if.sv ====
// Interface carrying the equalizer overflow events and their status bits.
// Assumes both ends run on clk_sys.
interface eqb_status_if;
    logic [4:0] ovf_event;
    logic [4:0] clear_mask;
    logic       clear_we;
    logic [4:0] sticky;
    modport bank (output clear_mask, output clear_we, input sticky, output ovf_event);
    modport flag (input clear_mask, input clear_we, output sticky, input ovf_event);
endinterface : eqb_status_if

// ==== logic/eqb_sticky_flags.sv ====
// Sticky overflow flags of the five equalizer bands.
// Assumes events and clears are synchronous to clk_sys.
module eqb_sticky_flags (
    input  wire logic   clk_sys,
    input  wire logic   rst,
    eqb_status_if.flag  st
);
    logic [4:0] flags_r;
    logic [4:0] flags_nxt;

    // A set in the clearing cycle wins over the clear.
    always_comb begin
        flags_nxt = flags_r;
        if (st.clear_we) begin
            flags_nxt = flags_nxt & ~st.clear_mask;
        end
        flags_nxt = flags_nxt | st.ovf_event;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flags_r <= 5'h00;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign st.sticky = flags_r;
endmodule : eqb_sticky_flags

// ==== logic/eqb_control_bank.sv ====
// Indexed control register bank: equalizer, auto volume control, pads,
// speaker halves, temperature thresholds and DAC reference select.
// Assumes a synchronous single-cycle host register port on clk_sys.
//
// Overview of operation
// - Equalizer control bit 15 enables the whole equalizer block.
// - Control bit 4 enables the high-pass band; clear bypasses and resets it.
// - Bits 3..1 enable band-pass stages three..one; clear resets that stage.
// - Control bit 0 enables the low-pass band; clear resets it.
// - Input attenuation code 1:0 gives 0, -6, -12, -18 dB.
// - Output gain code 2:0 gives -3 to 18 dB, default 001.
// - Auto volume config bit 15 enables auto volume on the ADC gain.
// - Window field 7:3 means 2^(n+1) samples, n up to 16, default 01010.
// - Auto volume config bit 0 picks left (0) or right (1) reference.
// - Fifteen-bit maximum target level, bit 15 reserved.
// - Fifteen-bit minimum target level.
// - Fifteen-bit idle level below which unity gain is kept.
// - Digital misc bit 15 selects strong pad drive, reset strong.
// - Digital misc bit 12 switches on the voice DAC high-pass test filter.
// - Speaker power bits 15..12 power the four class-AB halves.
// - Four three-bit over-temperature threshold codes, 25 to 125 degrees.
// - Mixer bits 14:13 select internal (01) or external (11) DAC reference.
// - Host writes a seven-bit index, then accesses 16 bits via index data.
// - An unavailable index reads back the contents of index 00.
// - Each band has a sticky overflow bit cleared by writing one.
module eqb_control_bank (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  host_addr,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    input  wire logic [4:0]  eq_band_overflow,
    input  wire logic [15:0] fallback_index_data,
    output logic             eq_block_enable,
    output logic             eq_hpf_enable,
    output logic      [2:0]  eq_bandpass_enable,
    output logic             eq_lpf_enable,
    output logic      [4:0]  eq_band_reset,
    output logic      [1:0]  eq_input_attenuation_code,
    output logic      [2:0]  eq_output_gain_code,
    output logic             auto_volume_control_enable,
    output logic      [4:0]  auto_volume_window_code,
    output logic             auto_volume_window_legal,
    output logic             auto_volume_right_ref,
    output logic      [14:0] auto_volume_max_level,
    output logic      [14:0] auto_volume_min_level,
    output logic      [14:0] auto_volume_idle_level,
    output logic      [15:0] gain_raise_count_limit,
    output logic      [15:0] gain_lower_count_limit,
    output logic             pad_strong_drive,
    output logic             voice_dac_hpf_on,
    output logic      [3:0]  speaker_half_power_on,
    output logic      [11:0] speaker_overtemp_codes,
    output logic             dac_ref_internal,
    output logic             dac_ref_external
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [eqb_pkg::INDEX_W-1:0] index_address_field_r;
    logic [eqb_pkg::INDEX_W-1:0] index_address_field_nxt;
    logic [15:0]                 regs_r   [eqb_pkg::NUM_REGS];
    logic [15:0]                 regs_nxt [eqb_pkg::NUM_REGS];
    logic [15:0]                 rdata_r;
    logic [15:0]                 rdata_nxt;

    eqb_status_if st ();

    eqb_sticky_flags u_flags (
        .clk_sys (clk_sys),
        .rst     (rst),
        .st      (st)
    );

    // Maps an index to its slot; slot NUM_REGS means not implemented.
    function automatic int slot_of(input logic [6:0] idx);
        unique case (idx)
            eqb_pkg::IDX_EQ_CTRL:   slot_of = 0;
            eqb_pkg::IDX_EQ_IN:     slot_of = 1;
            eqb_pkg::IDX_EQ_OUT:    slot_of = 2;
            eqb_pkg::IDX_AV_CFG:    slot_of = 3;
            eqb_pkg::IDX_AV_MAX:    slot_of = 4;
            eqb_pkg::IDX_AV_MIN:    slot_of = 5;
            eqb_pkg::IDX_AV_IDLE:   slot_of = 6;
            eqb_pkg::IDX_AV_RAISE:  slot_of = 7;
            eqb_pkg::IDX_AV_LOWER:  slot_of = 8;
            eqb_pkg::IDX_DIG_MISC:  slot_of = 9;
            eqb_pkg::IDX_SPK_POWER: slot_of = 10;
            eqb_pkg::IDX_SPK_TEMP:  slot_of = 11;
            eqb_pkg::IDX_MIX_REF:   slot_of = 12;
            default:                slot_of = eqb_pkg::NUM_REGS;
        endcase
    endfunction

    function automatic logic [15:0] mask_of(input int s);
        unique case (s)
            0:       mask_of = eqb_pkg::MASK_EQ_CTRL;
            1:       mask_of = eqb_pkg::MASK_EQ_IN;
            2:       mask_of = eqb_pkg::MASK_EQ_OUT;
            3:       mask_of = eqb_pkg::MASK_AV_CFG;
            4, 5, 6: mask_of = eqb_pkg::MASK_LEVEL15;
            11:      mask_of = eqb_pkg::MASK_SPK_TEMP;
            default: mask_of = eqb_pkg::MASK_FULL;
        endcase
    endfunction

    function automatic logic [15:0] reset_of(input int s);
        unique case (s)
            0:       reset_of = eqb_pkg::RST_EQ_CTRL;
            1:       reset_of = eqb_pkg::RST_EQ_IN;
            2:       reset_of = eqb_pkg::RST_EQ_OUT;
            3:       reset_of = eqb_pkg::RST_AV_CFG;
            4:       reset_of = eqb_pkg::RST_AV_MAX;
            5:       reset_of = eqb_pkg::RST_AV_MIN;
            6:       reset_of = eqb_pkg::RST_AV_IDLE;
            7:       reset_of = eqb_pkg::RST_AV_RAISE;
            8:       reset_of = eqb_pkg::RST_AV_LOWER;
            9:       reset_of = eqb_pkg::RST_DIG_MISC;
            10:      reset_of = eqb_pkg::RST_SPK_POWER;
            11:      reset_of = eqb_pkg::RST_SPK_TEMP;
            default: reset_of = eqb_pkg::RST_MIX_REF;
        endcase
    endfunction

    // ************************************************************
    // Host writes
    // ************************************************************
    logic wr_index;
    logic wr_data;
    logic wr_status;
    int   cur_slot;

    assign wr_index  = host_wr && (host_addr == eqb_pkg::HOST_INDEX_ADDR);
    assign wr_data   = host_wr && (host_addr == eqb_pkg::HOST_INDEX_DATA);
    assign wr_status = host_wr && (host_addr == eqb_pkg::HOST_EQ_STATUS);
    assign cur_slot  = slot_of(index_address_field_r);

    // A data write to an unimplemented index is dropped; only 7 index bits are kept.
    always_comb begin
        index_address_field_nxt = index_address_field_r;
        if (wr_index) begin
            index_address_field_nxt = host_wdata[eqb_pkg::INDEX_W-1:0];
        end
        for (int s = 0; s < eqb_pkg::NUM_REGS; s++) begin
            regs_nxt[s] = regs_r[s];
            if (wr_data && (cur_slot == s)) begin
                regs_nxt[s] = host_wdata & mask_of(s);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            index_address_field_r <= '0;
            for (int s = 0; s < eqb_pkg::NUM_REGS; s++) begin
                regs_r[s] <= reset_of(s);
            end
        end else begin
            index_address_field_r <= index_address_field_nxt;
            for (int s = 0; s < eqb_pkg::NUM_REGS; s++) begin
                regs_r[s] <= regs_nxt[s];
            end
        end
    end

    assign st.clear_we   = wr_status;
    assign st.clear_mask = host_wdata[4:0];
    assign st.ovf_event  = eq_band_overflow;

    // ************************************************************
    // Host reads
    // ************************************************************
    // Index 00 holds a filter coefficient kept outside this bank, so its
    // value is presented on fallback_index_data and echoed here.
    always_comb begin
        rdata_nxt = rdata_r;
        if (host_rd) begin
            unique case (host_addr)
                eqb_pkg::HOST_INDEX_ADDR: rdata_nxt = {9'h000, index_address_field_r};
                eqb_pkg::HOST_INDEX_DATA: begin
                    if (cur_slot < eqb_pkg::NUM_REGS) begin
                        rdata_nxt = regs_r[cur_slot];
                    end else begin
                        rdata_nxt = fallback_index_data;
                    end
                end
                eqb_pkg::HOST_EQ_STATUS:  rdata_nxt = {11'h000, st.sticky};
                default:                  rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign host_rdata = rdata_r;

    // ************************************************************
    // Control outputs
    // ************************************************************
    assign eq_block_enable    = regs_r[0][eqb_pkg::EQ_EN_BIT];
    assign eq_hpf_enable      = regs_r[0][4];
    assign eq_bandpass_enable = regs_r[0][3:1];
    assign eq_lpf_enable      = regs_r[0][0];
    // Band state is held in reset while its enable is low or the block is off.
    assign eq_band_reset      = ~(regs_r[0][4:0] & {5{eq_block_enable}});

    assign eq_input_attenuation_code = regs_r[1][1:0];
    assign eq_output_gain_code       = regs_r[2][2:0];

    assign auto_volume_control_enable = regs_r[3][eqb_pkg::AV_EN_BIT];
    assign auto_volume_window_code    = regs_r[3][eqb_pkg::AV_WIN_LSB +: 5];
    assign auto_volume_window_legal   = (auto_volume_window_code <= eqb_pkg::AV_WIN_MAX);
    assign auto_volume_right_ref      = regs_r[3][0];
    assign auto_volume_max_level      = regs_r[4][14:0];
    assign auto_volume_min_level      = regs_r[5][14:0];
    assign auto_volume_idle_level     = regs_r[6][14:0];
    assign gain_raise_count_limit     = regs_r[7];
    assign gain_lower_count_limit     = regs_r[8];

    assign pad_strong_drive      = regs_r[9][eqb_pkg::PAD_STRONG_BIT];
    assign voice_dac_hpf_on      = regs_r[9][eqb_pkg::VDAC_HPF_BIT];
    assign speaker_half_power_on = regs_r[10][eqb_pkg::SPK_PWR_LSB +: 4];
    assign speaker_overtemp_codes = {regs_r[11][14:12], regs_r[11][10:8],
                                     regs_r[11][6:4], regs_r[11][2:0]};
    // Reserved reference codes select neither source.
    assign dac_ref_internal = (regs_r[12][eqb_pkg::MIX_REF_LSB +: 2] == eqb_pkg::MIX_REF_INT);
    assign dac_ref_external = (regs_r[12][eqb_pkg::MIX_REF_LSB +: 2] == eqb_pkg::MIX_REF_EXT);

endmodule : eqb_control_bank

// ==== testbench/eqb_bank_monitor.sv ====
// Checker of the indexed control bank; it sees only the top module's ports.
// Assumes the single clk_sys domain, with rst asynchronous and active high.
module eqb_bank_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [7:0]  host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic        eq_block_enable,
    input wire logic        eq_hpf_enable,
    input wire logic [2:0]  eq_bandpass_enable,
    input wire logic        eq_lpf_enable,
    input wire logic [4:0]  eq_band_reset,
    input wire logic [1:0]  eq_input_attenuation_code,
    input wire logic [4:0]  auto_volume_window_code,
    input wire logic        auto_volume_window_legal,
    input wire logic        auto_volume_right_ref,
    input wire logic [3:0]  speaker_half_power_on,
    input wire logic        dac_ref_internal,
    input wire logic        dac_ref_external
);
    // ************************************************************
    // Index tracking
    // ************************************************************
    // The checker keeps its own copy of the index so that it never trusts the design's.
    logic [6:0] idx_r;
    wire logic  data_wr = host_wr && host_addr == 8'h6c;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            idx_r <= 7'h00;
        else if (host_wr && host_addr == 8'h6a)
            idx_r <= host_wdata[6:0];
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    band_reset_a: assert property (
        eq_band_reset == ~({eq_hpf_enable, eq_bandpass_enable, eq_lpf_enable} & {5{eq_block_enable}}))
        else $error("Band reset does not follow the enables.");
    block_en_a: assert property (
        data_wr && idx_r == 7'h10 |=> eq_block_enable == $past(host_wdata[15]))
        else $error("Equalizer enable not taken from write.");
    atten_a: assert property (
        data_wr && idx_r == 7'h11 |=> eq_input_attenuation_code == $past(host_wdata[1:0]))
        else $error("Attenuation code not taken from write.");
    av_cfg_a: assert property (
        data_wr && idx_r == 7'h20 |=> auto_volume_right_ref == $past(host_wdata[0])
            && auto_volume_window_code == $past(host_wdata[7:3]))
        else $error("Auto volume config not taken from write.");
    win_legal_a: assert property (
        auto_volume_window_legal == (auto_volume_window_code <= 5'h10))
        else $error("Window legality flag wrong.");
    spk_pwr_a: assert property (
        data_wr && idx_r == 7'h44 |=> speaker_half_power_on == $past(host_wdata[15:12]))
        else $error("Speaker half power not taken from write.");
    dac_ref_a: assert property (
        !(dac_ref_internal && dac_ref_external))
        else $error("Both DAC references selected.");
    idx_read_a: assert property (
        host_rd && host_addr == 8'h6a |=> host_rdata == {9'h000, $past(idx_r)})
        else $error("Index address read back wrong.");
    unmapped_a: assert property (
        host_rd && !(host_addr inside {8'h6a, 8'h6c, 8'h6e}) |=> host_rdata == 16'h0000)
        else $error("Unmapped read not zero.");
    status_a: assert property (
        host_rd && host_addr == 8'h6e |=> host_rdata[15:5] == 11'h000)
        else $error("Status reserved bits not zero.");
    hold_a: assert property (
        !host_wr |=> $stable({eq_block_enable, eq_band_reset, auto_volume_right_ref, speaker_half_power_on}))
        else $error("Control output moved without a write.");

    eq_on_c: cover property (data_wr && idx_r == 7'h10 && host_wdata[15]);
    status_c: cover property (host_rd && host_addr == 8'h6e);
    mix_c: cover property (data_wr && idx_r == 7'h54);
endmodule // eqb_bank_monitor

bind eqb_control_bank eqb_bank_monitor mon_u (.*);

// ==== testbench/tb.sv ====
// Self-checking bench of the indexed control bank through the host port.
// Assumes the bank alone, with index 00 data supplied as a constant.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0;
    logic [7:0]  host_addr = 8'h00;
    logic [15:0] host_wdata = 16'h0000, fallback_index_data = 16'h5a3c, host_rdata, v;
    logic [15:0] gain_raise_count_limit, gain_lower_count_limit;
    logic [4:0]  eq_band_overflow = 5'h00, eq_band_reset, auto_volume_window_code;
    logic        eq_block_enable, eq_hpf_enable, eq_lpf_enable, auto_volume_control_enable;
    logic        auto_volume_window_legal, auto_volume_right_ref, pad_strong_drive, voice_dac_hpf_on;
    logic        dac_ref_internal, dac_ref_external;
    logic [2:0]  eq_bandpass_enable, eq_output_gain_code;
    logic [1:0]  eq_input_attenuation_code;
    logic [14:0] auto_volume_max_level, auto_volume_min_level, auto_volume_idle_level;
    logic [3:0]  speaker_half_power_on;
    logic [11:0] speaker_overtemp_codes;
    int          miscompares = 0, n_checks = 0;
    localparam logic [6:0]  IDX [13] = '{7'h10, 7'h11, 7'h12, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
                                         7'h39, 7'h44, 7'h4a, 7'h54};
    localparam logic [15:0] RSTV [13] = '{16'h0000, 16'h0000, 16'h0001, 16'h0050, 16'h2710, 16'h0bb8,
        16'h01f4, 16'h0190, 16'h0200, 16'h9000, 16'hf920, 16'h4444, 16'h8184};
    localparam logic [15:0] MSK [13] = '{16'h801f, 16'h0003, 16'h0007, 16'h80f9, 16'h7fff, 16'h7fff,
        16'h7fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h7777, 16'hffff};

    eqb_control_bank dut_u (.*);
    always #10 clk_sys = ~clk_sys;

    // ************************************************************
    // Host port and comparison
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        #1 d = host_rdata;
    endtask
    task automatic iw(input logic [6:0] i, input logic [15:0] d);
        wr(8'h6a, {9'h000, i});
        wr(8'h6c, d);
    endtask
    task automatic ir(input logic [6:0] i, output logic [15:0] d);
        wr(8'h6a, {9'h000, i});
        rd(8'h6c, d);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_table();
        logic [15:0] d;
        for (int i = 0; i < 13; i++) begin
            ir(IDX[i], v);
            chk(v, RSTV[i]);
        end
        chk({15'h0, pad_strong_drive}, 16'h0001);
        // Writing all ones shows every reserved bit that fails to stay zero.
        // The raise count loses its low bit so that it stays below the lower count.
        for (int i = 0; i < 13; i++) begin
            d = (IDX[i] == 7'h24) ? 16'hfffe : 16'hffff;
            iw(IDX[i], d);
            ir(IDX[i], v);
            chk(v, MSK[i] & d);
        end
        chk({1'b0, auto_volume_max_level}, 16'h7fff);
        chk({1'b0, auto_volume_min_level}, 16'h7fff);
        chk({1'b0, auto_volume_idle_level}, 16'h7fff);
        chk(gain_raise_count_limit, 16'hfffe);
        chk(gain_lower_count_limit, 16'hffff);
        chk({14'h0, auto_volume_control_enable, auto_volume_window_legal}, 16'h0002);
    endtask
    task automatic t_eq();
        logic [15:0] w [4] = '{16'h8010, 16'h001f, 16'h801f, 16'h8005};
        logic [4:0]  r [4] = '{5'h0f, 5'h1f, 5'h00, 5'h1a};
        for (int i = 0; i < 4; i++) begin
            iw(7'h10, w[i]);
            chk({11'h0, eq_band_reset}, {11'h0, r[i]});
            chk({10'h0, eq_block_enable, eq_hpf_enable, eq_bandpass_enable, eq_lpf_enable},
                {10'h0, w[i][15], w[i][4:0]});
        end
    endtask
    // A mid-run reset stands in for the soft reset that must precede a window change.
    task automatic soft_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk(host_rdata, 16'h0000);
        chk({14'h0, auto_volume_control_enable, auto_volume_window_legal}, 16'h0001);
    endtask
    task automatic t_codes();
        for (int k = 0; k < 8; k++) begin
            iw(7'h11, 16'(k));
            chk({14'h0, eq_input_attenuation_code}, 16'(k & 3));
            iw(7'h12, 16'(k));
            chk({13'h0, eq_output_gain_code}, 16'(k));
        end
        soft_reset();
        iw(7'h20, 16'h8081);
        chk({13'h0, auto_volume_control_enable, auto_volume_window_legal, auto_volume_right_ref},
            16'h0007);
        soft_reset();
        iw(7'h20, 16'h0088);
        chk({13'h0, auto_volume_control_enable, auto_volume_window_legal, auto_volume_right_ref},
            16'h0000);
    endtask
    task automatic t_misc();
        logic [15:0] m [4] = '{16'h2000, 16'h6000, 16'h4000, 16'he184};
        iw(7'h39, 16'h1000);
        chk({14'h0, pad_strong_drive, voice_dac_hpf_on}, 16'h0001);
        iw(7'h44, 16'ha5a5);
        chk({12'h0, speaker_half_power_on}, 16'h000a);
        iw(7'h4a, 16'h7531);
        chk({4'h0, speaker_overtemp_codes}, {4'h0, 3'h7, 3'h5, 3'h3, 3'h1});
        for (int i = 0; i < 4; i++) begin
            iw(7'h54, m[i]);
            chk({14'h0, dac_ref_internal, dac_ref_external},
                {14'h0, m[i][14:13] == 2'b01, m[i][14:13] == 2'b11});
        end
    endtask
    task automatic t_fallback();
        iw(7'h7f, 16'h1234);
        rd(8'h6a, v);
        chk(v, 16'h007f);
        rd(8'h6c, v);
        chk(v, 16'h5a3c);
        rd(8'h70, v);
        chk(v, 16'h0000);
        wr(8'h6a, 16'hff85);
        rd(8'h6a, v);
        chk(v, 16'h0005);
        // The equalizer is switched off before a coefficient write, which this bank drops.
        iw(7'h10, 16'h0000);
        iw(7'h00, 16'h1234);
        ir(7'h00, v);
        chk(v, 16'h5a3c);
    endtask
    task automatic t_sticky();
        @(posedge clk_sys);
        eq_band_overflow <= 5'h05;
        @(posedge clk_sys);
        eq_band_overflow <= 5'h00;
        rd(8'h6e, v);
        chk(v, 16'h0005);
        // A clear that meets a new event in the same cycle must leave the flag set.
        @(posedge clk_sys);
        host_wr <= 1'b1;
        host_addr <= 8'h6e;
        host_wdata <= 16'hffe5;
        eq_band_overflow <= 5'h11;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        eq_band_overflow <= 5'h00;
        rd(8'h6e, v);
        chk(v, 16'h0011);
        wr(8'h6e, 16'h0001);
        rd(8'h6e, v);
        chk(v, 16'h0010);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_table();
        t_eq();
        t_codes();
        t_misc();
        t_fallback();
        t_sticky();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end
endmodule // tb
